// *** modbus_params.svh ***
// Constants of the RTU frame handler: function codes, exception codes, limits, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MODBUS_PARAMS_SVH
`define MODBUS_PARAMS_SVH
`define FN_READ 8'h03
`define FN_INPUT 8'h04
`define FN_ECHO 8'h08
`define FN_WRITE 8'h10
`define EXC_BIT 8'h80
`define EXC_FUNC 8'h01
`define EXC_REG 8'h02
`define EXC_DATA 8'h03
`define EXC_EXEC 8'h04
`define BCAST_ADDR 8'h00
`define DEF_ADDR 8'h01
`define MIN_LEN 9'h004
`define FIX_LEN 9'h008
`define WR_HDR 9'h009
`define WR_RESP_LEN 9'h006
`define EXC_LEN 9'h003
`define RD_HDR 9'h003
`define RD_MAX 16'h006A
`define WR_MAX 16'h0068
`define BUF_FULL 9'h100
`define WDATA_BASE 8'h07
`define RDATA_BASE 8'h03
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define CRC_GOOD 16'h0000
`define CRC_TAIL 9'h002
// 3.5 characters of 11 bits at 9600 baud, in ns.
`define GAP_NS 4010000
`define CLK_NS 50
`define GAP_CYC ((`GAP_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// *** modbus_pkg.sv ***
// Types of the RTU frame handler.
// Assumes modbus_params.svh is reachable by bare name.
`include "modbus_params.svh"
package modbus_pkg;
    typedef enum logic [5:0] {
        st_idle = 6'h01,
        st_check = 6'h02,
        st_scan = 6'h04,
        st_rpass = 6'h08,
        st_wpass = 6'h10,
        st_tx = 6'h20
    } state_e;
endpackage

// *** crc16_unit.sv ***
// Byte-wise CRC-16 accumulator, reflected polynomial, preset to all ones.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`include "modbus_params.svh"
module crc16_unit (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic en,
    input wire logic [7:0] byte_in,
    output logic [15:0] crc
);
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] v;
        v = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            v = v[0] ? ((v >> 1) ^ `CRC_POLY) : (v >> 1);
        end
        return v;
    endfunction

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            crc <= `CRC_INIT;
        end else if (clr) begin
            crc <= `CRC_INIT;
        end else if (en) begin
            crc <= crc_step(crc, byte_in);
        end
    end

    crc_preset_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clr |=> crc == `CRC_INIT) else $error("CRC not preset after clear.");
    crc_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !clr && !en |=> $stable(crc)) else $error("CRC changed without a byte.");
endmodule

// *** rtu_frame_handler.sv ***
// RTU slave frame handler: frame capture, checks, decode, register access, response.
// Assumes a byte receiver and transmitter outside, and a register map behind reg_* ports
// that answers reg_rdata, reg_exists and reg_writable combinationally from reg_addr/reg_wdata.
//
// Behaviour
// - Bad address, line error, bad CRC: silent drop
// - Wrong frame length for function: silent drop
// - Broadcast address zero never answered
// - Unknown function 01, missing register 02, prioritised
// - Bad count or byte count gives 03
// - Unwritable value gives exception 04
// - Only functions 03, 04, 08, 10 accepted
// - Function 04 handled as read
// - Echo returns received frame unchanged
// - Registers 16 bits, two bytes each
// - High byte first, wide values consecutive
// - Read count 1 to 106, all existing
// - Read reply: address, function, byte count, data
// - Unconfigured station answers address one
// - CRC-16 A001, preset FFFF, low first
// - Exception reply: function with bit 7
`timescale 1ns/1ns
`include "modbus_params.svh"
module rtu_frame_handler
    import modbus_pkg::*;
#(
    parameter int GAP_CYCLES = `GAP_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_error,
    input wire logic addr_set,
    input wire logic [7:0] station_addr,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_rd,
    output logic reg_wr,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_exists,
    input wire logic reg_writable,
    output logic frame_drop
);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pos(input logic [7:0] base, input logic [8:0] i);
        return base + {i[6:0], 1'b0};
    endfunction

    state_e state;
    logic [7:0] mem [0:255];
    logic [8:0] len;
    logic [8:0] idx;
    logic [31:0] gap;
    logic rx_bad;
    logic [15:0] start;
    logic [15:0] count;
    logic wr_mode;
    logic phase;
    logic miss;
    logic nowr;
    logic append;
    logic quiet;
    logic [15:0] crc_val;
    logic [7:0] own;
    logic [7:0] fn;
    logic hdr_ok;
    logic is_rd;
    logic is_wr;
    logic is_echo;
    logic fn_known;
    logic len_ok;
    logic cnt_ok;
    logic [15:0] cnt;
    logic last;
    logic miss_n;
    logic nowr_n;
    logic do_exc;
    logic [7:0] exc_code;
    logic [8:0] tx_end;
    logic tx_take;
    logic crc_clr;
    logic crc_en;
    logic [7:0] crc_byte;
    logic [15:0] tx_word;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame decode, valid in the check state.
    always_comb begin
        own = addr_set ? station_addr : `DEF_ADDR;
        fn = mem[1];
        cnt = {mem[4], mem[5]};
        hdr_ok = !rx_bad && len >= `MIN_LEN && crc_val == `CRC_GOOD
            && (mem[0] == own || mem[0] == `BCAST_ADDR);
        is_rd = fn == `FN_READ || fn == `FN_INPUT;
        is_wr = fn == `FN_WRITE;
        is_echo = fn == `FN_ECHO;
        fn_known = is_rd || is_wr || is_echo;
        len_ok = is_wr ? (len >= `WR_HDR && len == `WR_HDR + {1'b0, mem[6]})
            : (len == `FIX_LEN);
        cnt_ok = cnt != 16'h0000 && cnt <= (is_wr ? `WR_MAX : `RD_MAX)
            && (!is_wr || {cnt[6:0], 1'b0} == mem[6]);
        last = {7'h00, idx} == count - 16'h0001;
        miss_n = miss || !reg_exists;
        nowr_n = nowr || (wr_mode && !reg_writable);
        do_exc = 1'b0;
        exc_code = `EXC_FUNC;
        if (state == st_check && hdr_ok) begin
            if (!fn_known) begin
                do_exc = 1'b1;
            end else if (len_ok && !is_echo && !cnt_ok) begin
                do_exc = 1'b1;
                exc_code = `EXC_DATA;
            end
        end else if (state == st_scan && phase && last && (miss_n || nowr_n)) begin
            do_exc = 1'b1;
            exc_code = miss_n ? `EXC_REG : `EXC_EXEC;
        end
        tx_end = append ? len + `CRC_TAIL : len;
        tx_take = state == st_tx && (!tx_valid || tx_ready);
        tx_word = {mem[pos(`WDATA_BASE, idx)], mem[pos(`WDATA_BASE, idx) + 8'h01]};
        crc_clr = (state != st_idle && state != st_tx) || (state == st_idle && len == 9'h000
            && !rx_valid);
        crc_en = (state == st_idle && rx_valid) || (tx_take && idx < len);
        crc_byte = state == st_idle ? rx_data : mem[idx[7:0]];
    end

    crc16_unit crc_inst (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clr(crc_clr),
        .en(crc_en),
        .byte_in(crc_byte),
        .crc(crc_val)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Inter-frame idle timer.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gap <= 32'h0000_0000;
        end else if (state != st_idle || rx_valid) begin
            gap <= 32'h0000_0000;
        end else if (gap != GAP_CYCLES - 1) begin
            gap <= gap + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame buffer: request bytes, read data and reply header rewrites.
    always_ff @(posedge sys_clk) begin
        if (state == st_idle && rx_valid && len != `BUF_FULL) begin
            mem[len[7:0]] <= rx_data;
        end else if (do_exc) begin
            mem[1] <= mem[1] | `EXC_BIT;
            mem[2] <= exc_code;
        end else if (state == st_rpass && phase) begin
            mem[pos(`RDATA_BASE, idx)] <= reg_rdata[15:8];
            mem[pos(`RDATA_BASE, idx) + 8'h01] <= reg_rdata[7:0];
            if (last) begin
                mem[2] <= {count[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= st_idle;
            len <= 9'h000;
            idx <= 9'h000;
            rx_bad <= 1'b0;
            start <= 16'h0000;
            count <= 16'h0000;
            wr_mode <= 1'b0;
            phase <= 1'b0;
            miss <= 1'b0;
            nowr <= 1'b0;
            append <= 1'b0;
            quiet <= 1'b0;
            frame_drop <= 1'b0;
            reg_rd <= 1'b0;
            reg_wr <= 1'b0;
            reg_addr <= 16'h0000;
            reg_wdata <= 16'h0000;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
        end else begin
            frame_drop <= 1'b0;
            reg_rd <= 1'b0;
            reg_wr <= 1'b0;
            case (state)
                st_idle: begin
                    if (rx_valid) begin
                        if (len == `BUF_FULL) begin
                            rx_bad <= 1'b1;
                        end else begin
                            len <= len + 9'h001;
                        end
                        if (len == 9'h000) begin
                            quiet <= 1'b0;
                        end
                    end
                    if (rx_error) begin
                        rx_bad <= 1'b1;
                    end
                    if (len != 9'h000 && !rx_valid && gap == GAP_CYCLES - 1) begin
                        state <= st_check;
                    end
                end
                st_check: begin
                    start <= {mem[2], mem[3]};
                    count <= cnt;
                    wr_mode <= is_wr;
                    quiet <= mem[0] == `BCAST_ADDR;
                    idx <= 9'h000;
                    phase <= 1'b0;
                    miss <= 1'b0;
                    nowr <= 1'b0;
                    rx_bad <= 1'b0;
                    append <= 1'b1;
                    if (!hdr_ok || (fn_known && !len_ok)) begin
                        state <= st_idle;
                        len <= 9'h000;
                        frame_drop <= 1'b1;
                    end else if (do_exc) begin
                        len <= `EXC_LEN;
                        state <= mem[0] == `BCAST_ADDR ? st_idle : st_tx;
                    end else if (is_echo) begin
                        append <= 1'b0;
                        state <= mem[0] == `BCAST_ADDR ? st_idle : st_tx;
                    end else begin
                        state <= st_scan;
                    end
                    if (mem[0] == `BCAST_ADDR && (do_exc || is_echo)) begin
                        len <= 9'h000;
                    end
                end
                st_scan, st_rpass, st_wpass: begin
                    phase <= !phase;
                    if (!phase) begin
                        reg_addr <= start + {7'h00, idx};
                        reg_wdata <= tx_word;
                        reg_rd <= state == st_rpass;
                        reg_wr <= state == st_wpass;
                    end else begin
                        idx <= last ? 9'h000 : idx + 9'h001;
                        if (state == st_scan) begin
                            miss <= miss_n;
                            nowr <= nowr_n;
                        end
                        if (last) begin
                            if (do_exc) begin
                                len <= `EXC_LEN;
                                state <= quiet ? st_idle : st_tx;
                            end else if (state == st_scan) begin
                                state <= wr_mode ? st_wpass : st_rpass;
                            end else begin
                                len <= state == st_rpass ? `RD_HDR + {count[7:0], 1'b0}
                                    : `WR_RESP_LEN;
                                state <= quiet ? st_idle : st_tx;
                            end
                            if (quiet && (do_exc || state != st_scan)) begin
                                len <= 9'h000;
                            end
                        end
                    end
                end
                st_tx: begin
                    if (tx_take) begin
                        if (idx == tx_end) begin
                            tx_valid <= 1'b0;
                            len <= 9'h000;
                            idx <= 9'h000;
                            state <= st_idle;
                        end else begin
                            tx_valid <= 1'b1;
                            idx <= idx + 9'h001;
                            if (idx < len) begin
                                tx_data <= mem[idx[7:0]];
                            end else if (idx == len) begin
                                tx_data <= crc_val[7:0];
                            end else begin
                                tx_data <= crc_val[15:8];
                            end
                        end
                    end
                end
                default: begin
                    state <= st_idle;
                    len <= 9'h000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence rd_issue;
        ##1 reg_rd ##1 !reg_rd;
    endsequence
    sequence exc_written(logic [7:0] code);
        ##1 (mem[2] == code && mem[1][7]);
    endsequence

    drop_silent_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state == st_check && !hdr_ok |=> state == st_idle && frame_drop && !tx_valid)
        else $error("Bad frame was not dropped.");
    len_drop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state == st_check && hdr_ok && is_rd && len != `FIX_LEN |=> state == st_idle)
        else $error("Wrong-length read was not dropped.");
    bcast_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        quiet |-> state != st_tx && !tx_valid) else $error("Broadcast was answered.");
    exc_unsup_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state == st_check && hdr_ok && !fn_known |-> exc_written(`EXC_FUNC))
        else $error("Unknown function not reported as 01.");
    exc_range_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state == st_check && hdr_ok && is_rd && len == `FIX_LEN && cnt == 16'h0000
        |-> exc_written(`EXC_DATA)) else $error("Zero count not reported as 03.");
    echo_plain_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state == st_check && hdr_ok && is_echo && len == `FIX_LEN && mem[0] != `BCAST_ADDR
        |=> state == st_tx && !append) else $error("Echo not sent unchanged.");
    rd_strobe_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state == st_rpass && !phase |-> rd_issue) else $error("Read strobe malformed.");
    wr_guard_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr |-> !miss && !nowr && wr_mode) else $error("Write despite failed check.");
    tx_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("Reply byte dropped under back-pressure.");
endmodule

// *** rtu_host_model.sv ***
// Bus host model: sends request frames byte by byte and collects reply bytes.
// Assumes the handler's byte ports; the bench calls send and reads got.
`timescale 1ns/1ns
module rtu_host_model (
    input wire logic sys_clk,
    input wire logic nrst,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic [7:0] got[$];
    logic [2:0] stall;
    initial begin
        rx_data = 8'hA5;
        rx_valid = 1'b0;
    end
    // Ready drops two cycles in eight, so replies see back pressure.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stall <= 3'h0;
            tx_ready <= 1'b0;
        end else begin
            stall <= stall + 3'h1;
            tx_ready <= stall != 3'h5 && stall != 3'h6;
            if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_data);
        end
    end
    // Sends bytes two cycles apart; between bytes the line shows the inverse value.
    task automatic send(input logic [7:0] f[$]);
        foreach (f[i]) begin
            @(posedge sys_clk);
            rx_data <= f[i];
            rx_valid <= 1'b1;
            @(posedge sys_clk);
            rx_valid <= 1'b0;
            rx_data <= ~f[i];
        end
    endtask
endmodule

// *** test_rtu_frame_handler.sv ***
// Self-checking bench of the RTU frame handler with a host model and a register map.
// Assumes the handler built with a short idle gap of 20 cycles.
`timescale 1ns/1ns
module test_rtu_frame_handler;
    typedef logic [7:0] bq_t[$];
    typedef logic [15:0] wq_t[$];
    logic sys_clk, nrst, rx_error, addr_set, tx_valid, tx_ready, reg_rd, reg_wr, frame_drop;
    logic [7:0] rx_data, station_addr, tx_data;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_exists, reg_writable, rx_valid;
    logic [15:0] mem[0:255];
    logic [15:0] shadow[0:255];
    int n_fail, tests_run, n_drop, n_rd, seed;
    bq_t b, none;
    wq_t ws;
    rtu_frame_handler #(.GAP_CYCLES(20)) i_dut (.sys_clk(sys_clk), .nrst(nrst),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_error(rx_error), .addr_set(addr_set),
        .station_addr(station_addr), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_rdata(reg_rdata), .reg_exists(reg_exists),
        .reg_writable(reg_writable), .frame_drop(frame_drop));
    rtu_host_model i_host (.sys_clk(sys_clk), .nrst(nrst), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    ////////////////////////////////////////////////////////////////////////////////
    // Register map: 2000..2004 read only, 3000..30FF writable below 0100.
    assign reg_exists = reg_addr[15:8] == 8'h30 || (reg_addr >= 16'h2000 && reg_addr <= 16'h2004);
    assign reg_writable = reg_addr[15:8] == 8'h30 && reg_wdata < 16'h0100;
    assign reg_rdata = reg_addr[15:8] == 8'h30 ? mem[reg_addr[7:0]] : ~reg_addr;
    always @(posedge sys_clk) if (reg_wr === 1'b1) mem[reg_addr[7:0]] <= reg_wdata;
    always @(posedge sys_clk) if (frame_drop === 1'b1) n_drop++;
    always @(posedge sys_clk) if (reg_rd === 1'b1) n_rd++;
    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] crc16(input bq_t f);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    function automatic bq_t seal(input bq_t q);
        logic [15:0] c;
        c = crc16(q);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        return q;
    endfunction
    function automatic bq_t rd(input logic [7:0] st, fn, input logic [15:0] a, n);
        return {st, fn, a[15:8], a[7:0], n[15:8], n[7:0]};
    endfunction
    function automatic bq_t rr(input logic [7:0] st, fn, input logic [15:0] a, input int n);
        bq_t q;
        logic [15:0] w, x;
        q = {st, fn, 8'(2 * n)};
        for (int i = 0; i < n; i++) begin
            x = a + 16'(i);
            w = x[15:8] == 8'h30 ? shadow[x[7:0]] : ~x;
            q.push_back(w[15:8]);
            q.push_back(w[7:0]);
        end
        return q;
    endfunction
    function automatic bq_t wr(input logic [7:0] st, input logic [15:0] a, input wq_t d);
        bq_t q;
        q = {st, 8'h10, a[15:8], a[7:0], 8'h00, 8'(d.size()), 8'(2 * d.size())};
        foreach (d[i]) q = {q, d[i][15:8], d[i][7:0]};
        return q;
    endfunction
    function automatic bq_t wrsp(input logic [7:0] st, input logic [15:0] a, n);
        return {st, 8'h10, a[15:8], a[7:0], n[15:8], n[7:0]};
    endfunction
    function automatic bq_t exc(input logic [7:0] st, fn, code);
        return {st, fn | 8'h80, code};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check_byte(input string what, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_int(input string what, input int e, g);
        tests_run++;
        if (g != e) begin
            n_fail++;
            $display("MISMATCH %s expected %0d seen %0d", what, e, g);
        end
    endtask
    // Mode 1 corrupts the last byte, mode 2 flags a line error; drop 2 skips that count.
    task automatic run(input bq_t req, input bq_t exp, input int mode, input int drop);
        int d0, k;
        d0 = n_drop;
        k = 0;
        i_host.got.delete();
        if (mode == 1) req[req.size() - 1] ^= 8'h01;
        if (mode == 2) rx_error <= 1'b1;
        i_host.send(req);
        rx_error <= 1'b0;
        while (i_host.got.size() < exp.size() && k < 2000) begin
            @(posedge sys_clk);
            k++;
        end
        if (i_host.got.size() < exp.size()) begin
            n_fail++;
            $display("MISMATCH reply wait expected %0d seen %0d", exp.size(), i_host.got.size());
            conclude();
        end
        repeat (400) @(posedge sys_clk);
        check_int("reply length", exp.size(), i_host.got.size());
        foreach (exp[i]) if (i < i_host.got.size())
            check_byte("reply byte", exp[i], i_host.got[i]);
        if (drop < 2) check_int("drops", drop, n_drop - d0);
    endtask
    // A good read must also give as many read strobes in total as registers requested.
    task automatic rdok(input logic [7:0] st, fn, input logic [15:0] a, input int n);
        int r0;
        r0 = n_rd;
        run(seal(rd(st, fn, a, 16'(n))), seal(rr(st, fn, a, n)), 0, 0);
        check_int("read strobes", n, n_rd - r0);
    endtask
    task automatic rdex(input logic [7:0] fn, input logic [15:0] a, n, input logic [7:0] code);
        run(seal(rd(8'h01, fn, a, n)), seal(exc(8'h01, fn, code)), 0, 0);
    endtask
    task automatic wrok(input logic [15:0] a, input wq_t d);
        run(seal(wr(8'h01, a, d)), seal(wrsp(8'h01, a, 16'(d.size()))), 0, 0);
        foreach (d[i]) shadow[a[7:0] + 8'(i)] = d[i];
        rdok(8'h01, 8'h03, a, d.size());
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h6B74D483;
        nrst = 1'b0;
        rx_error = 1'b0;
        addr_set = 1'b0;
        station_addr = 8'h11;
        for (int i = 0; i < 256; i++) mem[i] = 16'(i * 3);
        for (int i = 0; i < 256; i++) shadow[i] = 16'(i * 3);
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        rdok(8'h01, 8'h03, 16'h2000, 1);
        rdok(8'h01, 8'h04, 16'h2002, 3);
        b = {8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34, 8'hED, 8'h7C};
        run(b, b, 0, 0);
        ws = {16'h0005, 16'h0007};
        wrok(16'h3000, ws);
        rdok(8'h01, 8'h03, 16'h3000, 106);
        rdex(8'h03, 16'h3000, 16'h006B, 8'h03);
        rdex(8'h03, 16'h3000, 16'h0000, 8'h03);
        rdex(8'h03, 16'h2004, 16'h0002, 8'h02);
        rdex(8'h05, 16'h1000, 16'h0001, 8'h01);
        rdex(8'h06, 16'h3000, 16'h0001, 8'h01);
        ws = {16'h0200};
        run(seal(wr(8'h01, 16'h3001, ws)), seal(exc(8'h01, 8'h10, 8'h04)), 0, 0);
        rdok(8'h01, 8'h03, 16'h3001, 1);
        // Register count of two against a byte count of two: the frame length stays consistent.
        b = wr(8'h01, 16'h3001, ws);
        b[5] = 8'h02;
        run(seal(b), seal(exc(8'h01, 8'h10, 8'h03)), 0, 0);
        run(seal(rd(8'h22, 8'h03, 16'h2000, 1)), none, 0, 1);
        run(seal(rd(8'h01, 8'h03, 16'h2000, 1)), none, 1, 1);
        run(seal(rd(8'h01, 8'h03, 16'h2000, 1)), none, 2, 1);
        b = rd(8'h01, 8'h03, 16'h2000, 1);
        b.push_back(8'h00);
        run(seal(b), none, 0, 1);
        ws = {16'h0033};
        run(seal(wr(8'h00, 16'h3002, ws)), none, 0, 2);
        shadow[2] = 16'h0033;
        rdok(8'h01, 8'h03, 16'h3002, 1);
        addr_set <= 1'b1;
        run(seal(rd(8'h01, 8'h03, 16'h2000, 1)), none, 0, 1);
        rdok(8'h11, 8'h03, 16'h2001, 2);
        addr_set <= 1'b0;
        repeat (8) begin
            ws.delete();
            repeat (1 + ($unsigned($random(seed)) % 8)) ws.push_back({8'h00, 8'($random(seed))});
            wrok({8'h30, 8'($random(seed)) & 8'hF0}, ws);
        end
        conclude();
    end
endmodule
